/* verilog/pace_beat_map.svh */
// Register map, field positions and reset values of the pace and beat config bank
// Assumes byte addressing on APB with one 32-bit word per register
`ifndef PACE_BEAT_MAP_SVH
`define PACE_BEAT_MAP_SVH

`define PACING_CONFIG_IDX       8'h1A
`define BEAT_CONFIG_A_IDX       8'h1D
`define BEAT_CONFIG_B_IDX       8'h1E
`define ECG_CONTROL_IDX         8'h20

`define PACING_CONFIG_MASK      24'h8F70FF
`define BEAT_CONFIG_A_MASK      24'hFFBF00
`define BEAT_CONFIG_B_MASK      24'h3F3700
`define ECG_CONTROL_MASK        24'h000001

`define PACING_CONFIG_RESET     24'h000055
`define BEAT_CONFIG_A_RESET     24'h3F2300
`define BEAT_CONFIG_B_RESET     24'h202200
`define ECG_CONTROL_RESET       24'h000000

`define POLARITY_BIT            23
`define DERIV_BYPASS_BIT        19
`define PACE_GAIN_HI            18
`define PACE_GAIN_LO            16
`define MON_LBW_BIT             14
`define MON_SRC_HI              13
`define MON_SRC_LO              12
`define POS_THR_HI              7
`define POS_THR_LO              4
`define NEG_THR_HI              3
`define NEG_THR_LO              0

`define WINDOW_HI               23
`define WINDOW_LO               20
`define BGAIN_HI                19
`define BGAIN_LO                16
`define BEAT_EN_BIT             15
`define PEAK_AVG_HI             13
`define PEAK_AVG_LO             12
`define PEAK_SCALE_HI           11
`define PEAK_SCALE_LO           8

`define HOLDOFF_HI              21
`define HOLDOFF_LO              16
`define INTERVAL_AVG_HI         13
`define INTERVAL_AVG_LO         12
`define HOLDOFF_SCALE_HI        10
`define HOLDOFF_SCALE_LO        8

`define ECG_EN_BIT              0

`endif

/* verilog/pace_beat_pkg.sv */
// Types shared by the pace and beat config bank
// Assumes the map header supplies all numbers
package pace_beat_pkg;

    typedef logic [23:0] reg_word_t;

    typedef enum logic [1:0]
    {
        MON_OFF   = 2'b00,
        MON_FIRST = 2'b01,
        MON_GAIN  = 2'b10,
        MON_COMP  = 2'b11
    } monitor_source_e;

endpackage

/* verilog/masked_config_reg.sv */
// One 24-bit software register with a write mask
// Assumes write strobe is a single-cycle APB access-phase pulse
`timescale 1ns/1ps

module masked_config_reg #(
    parameter int                   WIDTH = 24,
    parameter logic [WIDTH-1:0]     MASK  = '1,
    parameter logic [WIDTH-1:0]     RESET = '0
) (
    // Clock and reset
    input  wire logic               pclk,
    input  wire logic               presetn,
    // Write port
    input  wire logic               wr_en,
    input  wire logic [WIDTH-1:0]   wr_data,
    input  wire logic [3:0]         wr_strb,
    // Stored value
    output logic      [WIDTH-1:0]   value
);

    logic [WIDTH-1:0] value_r;
    logic [WIDTH-1:0] value_nxt;
    logic [WIDTH-1:0] lane_mask;

    initial
    begin
        if (WIDTH < 1 || WIDTH > 32)
            $error("masked_config_reg width out of range");
    end

    always_comb
    begin
        for (int i = 0; i < WIDTH; i++)
            lane_mask[i] = wr_strb[i / 8];
        value_nxt = value_r;
        if (wr_en)
            // Unused bits never store, so they read back zero
            value_nxt = ((value_r & ~lane_mask) | (wr_data & lane_mask)) & MASK;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            value_r <= RESET & MASK;
        else
            value_r <= value_nxt;
    end

    assign value = value_r;

endmodule

/* verilog/pace_beat_config_regs.sv */
// Pacing channel and beat-interval detector configuration registers on APB
// Assumes an APB master on pclk; analog and detector logic sit outside
//
// The APB register port was decided locally.
`timescale 1ns/1ps
`include "pace_beat_map.svh"

module pace_beat_config_regs #(
    parameter int ADDR_W = 12
) (
    // Clock and reset
    input  wire logic               pclk,
    input  wire logic               presetn,
    // APB slave
    input  wire logic               psel,
    input  wire logic               penable,
    input  wire logic               pwrite,
    input  wire logic [ADDR_W-1:0]  paddr,
    input  wire logic [31:0]        pwdata,
    input  wire logic [3:0]         pstrb,
    output logic                    pready,
    output logic      [31:0]        prdata,
    output logic                    pslverr,
    // Pacing channel controls
    output logic                    pacing_input_polarity,
    output logic                    derivative_stage_bypass,
    output logic      [2:0]         pacing_gain_code,
    output logic                    monitor_buffer_low_bandwidth,
    output pace_beat_pkg::monitor_source_e monitor_output_source,
    output logic      [3:0]         positive_threshold_code,
    output logic      [3:0]         negative_threshold_code,
    // Beat detector controls
    output logic      [3:0]         beat_window_width,
    output logic      [3:0]         beat_detect_gain,
    output logic      [1:0]         peak_average_weight,
    output logic      [3:0]         peak_threshold_scale,
    output logic      [5:0]         min_holdoff_count,
    output logic      [1:0]         interval_average_weight,
    output logic      [2:0]         holdoff_scale_factor,
    output logic                    beat_detector_run
);

    initial
    begin
        if (ADDR_W < 8)
            $error("ADDR_W too small for register map");
    end

    ////////////////////////////////////////////////////////////////////////////
    // Bus decode

    logic [ADDR_W-1:0] pacing_addr;
    logic [ADDR_W-1:0] beat_a_addr;
    logic [ADDR_W-1:0] beat_b_addr;
    logic [ADDR_W-1:0] ecg_addr;
    logic              access;
    logic              wr_access;
    logic              hit_pacing;
    logic              hit_beat_a;
    logic              hit_beat_b;
    logic              hit_ecg;
    logic              hit_any;

    // Printed offsets are word indexes; byte address is four times that
    assign pacing_addr = ADDR_W'({`PACING_CONFIG_IDX, 2'b00});
    assign beat_a_addr = ADDR_W'({`BEAT_CONFIG_A_IDX, 2'b00});
    assign beat_b_addr = ADDR_W'({`BEAT_CONFIG_B_IDX, 2'b00});
    assign ecg_addr    = ADDR_W'({`ECG_CONTROL_IDX, 2'b00});

    // Zero-wait slave: every access phase completes at once
    assign access     = psel & penable;
    assign wr_access  = access & pwrite;
    assign hit_pacing = (paddr == pacing_addr);
    assign hit_beat_a = (paddr == beat_a_addr);
    assign hit_beat_b = (paddr == beat_b_addr);
    assign hit_ecg    = (paddr == ecg_addr);
    assign hit_any    = hit_pacing | hit_beat_a | hit_beat_b | hit_ecg;

    ////////////////////////////////////////////////////////////////////////////
    // Storage

    pace_beat_pkg::reg_word_t pacing_q;
    pace_beat_pkg::reg_word_t beat_a_q;
    pace_beat_pkg::reg_word_t beat_b_q;
    pace_beat_pkg::reg_word_t ecg_q;

    // Pacing fields; no resync is forced here, software owns that step
    masked_config_reg #(
        .WIDTH (24),
        .MASK  (`PACING_CONFIG_MASK),
        .RESET (`PACING_CONFIG_RESET)
    ) u_pacing (
        .pclk    (pclk),
        .presetn (presetn),
        .wr_en   (wr_access & hit_pacing),
        .wr_data (pwdata[23:0]),
        .wr_strb (pstrb),
        .value   (pacing_q)
    );

    masked_config_reg #(
        .WIDTH (24),
        .MASK  (`BEAT_CONFIG_A_MASK),
        .RESET (`BEAT_CONFIG_A_RESET)
    ) u_beat_a (
        .pclk    (pclk),
        .presetn (presetn),
        .wr_en   (wr_access & hit_beat_a),
        .wr_data (pwdata[23:0]),
        .wr_strb (pstrb),
        .value   (beat_a_q)
    );

    masked_config_reg #(
        .WIDTH (24),
        .MASK  (`BEAT_CONFIG_B_MASK),
        .RESET (`BEAT_CONFIG_B_RESET)
    ) u_beat_b (
        .pclk    (pclk),
        .presetn (presetn),
        .wr_en   (wr_access & hit_beat_b),
        .wr_data (pwdata[23:0]),
        .wr_strb (pstrb),
        .value   (beat_b_q)
    );

    // ECG channel enable lives here since no other block supplies it
    masked_config_reg #(
        .WIDTH (24),
        .MASK  (`ECG_CONTROL_MASK),
        .RESET (`ECG_CONTROL_RESET)
    ) u_ecg (
        .pclk    (pclk),
        .presetn (presetn),
        .wr_en   (wr_access & hit_ecg),
        .wr_data (pwdata[23:0]),
        .wr_strb (pstrb),
        .value   (ecg_q)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Read path and response

    logic [31:0] prdata_r;
    logic [31:0] prdata_nxt;
    logic        pready_r;
    logic        pready_nxt;
    logic        pslverr_r;
    logic        pslverr_nxt;

    always_comb
    begin
        // Ready is registered, so it rises in the first access cycle
        pready_nxt  = psel & ~penable;
        pslverr_nxt = psel & ~penable & ~hit_any;
        prdata_nxt  = 32'h00000000;
        if (psel && !penable && !pwrite)
        begin
            unique case (1'b1)
                hit_pacing: prdata_nxt = {8'h00, pacing_q};
                hit_beat_a: prdata_nxt = {8'h00, beat_a_q};
                hit_beat_b: prdata_nxt = {8'h00, beat_b_q};
                hit_ecg:    prdata_nxt = {8'h00, ecg_q};
                default:    prdata_nxt = 32'h00000000;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            prdata_r  <= 32'h00000000;
            pready_r  <= 1'b0;
            pslverr_r <= 1'b0;
        end
        else
        begin
            prdata_r  <= prdata_nxt;
            pready_r  <= pready_nxt;
            pslverr_r <= pslverr_nxt;
        end
    end

    assign prdata  = prdata_r;
    assign pready  = pready_r;
    assign pslverr = pslverr_r;

    ////////////////////////////////////////////////////////////////////////////
    // Field outputs, one flop stage from the stored words
    // One flop per field, so every output leaves the block registered

    // Reset values follow the masked stored words, so fields agree with reads
    localparam pace_beat_pkg::reg_word_t PACE_RST   = `PACING_CONFIG_RESET & `PACING_CONFIG_MASK;
    localparam pace_beat_pkg::reg_word_t BEAT_A_RST = `BEAT_CONFIG_A_RESET & `BEAT_CONFIG_A_MASK;
    localparam pace_beat_pkg::reg_word_t BEAT_B_RST = `BEAT_CONFIG_B_RESET & `BEAT_CONFIG_B_MASK;

    logic                           polarity_r;
    logic                           polarity_nxt;
    logic                           bypass_r;
    logic                           bypass_nxt;
    logic [2:0]                     gain_r;
    logic [2:0]                     gain_nxt;
    logic                           low_bw_r;
    logic                           low_bw_nxt;
    pace_beat_pkg::monitor_source_e source_r;
    pace_beat_pkg::monitor_source_e source_nxt;
    logic [3:0]                     pos_thr_r;
    logic [3:0]                     pos_thr_nxt;
    logic [3:0]                     neg_thr_r;
    logic [3:0]                     neg_thr_nxt;
    logic [3:0]                     window_r;
    logic [3:0]                     window_nxt;
    logic [3:0]                     beat_gain_r;
    logic [3:0]                     beat_gain_nxt;
    logic [1:0]                     peak_avg_r;
    logic [1:0]                     peak_avg_nxt;
    logic [3:0]                     peak_scale_r;
    logic [3:0]                     peak_scale_nxt;
    logic [5:0]                     holdoff_r;
    logic [5:0]                     holdoff_nxt;
    logic [1:0]                     interval_avg_r;
    logic [1:0]                     interval_avg_nxt;
    logic [2:0]                     holdoff_scale_r;
    logic [2:0]                     holdoff_scale_nxt;
    logic                           run_r;
    logic                           run_nxt;

    always_comb
    begin
        polarity_nxt      = pacing_q[`POLARITY_BIT];
        bypass_nxt        = pacing_q[`DERIV_BYPASS_BIT];
        gain_nxt          = pacing_q[`PACE_GAIN_HI:`PACE_GAIN_LO];
        // Bandwidth only matters while the monitor is sourced
        low_bw_nxt        = pacing_q[`MON_LBW_BIT];
        source_nxt        = pace_beat_pkg::monitor_source_e'(pacing_q[`MON_SRC_HI:`MON_SRC_LO]);
        pos_thr_nxt       = pacing_q[`POS_THR_HI:`POS_THR_LO];
        neg_thr_nxt       = pacing_q[`NEG_THR_HI:`NEG_THR_LO];
        window_nxt        = beat_a_q[`WINDOW_HI:`WINDOW_LO];
        beat_gain_nxt     = beat_a_q[`BGAIN_HI:`BGAIN_LO];
        peak_avg_nxt      = beat_a_q[`PEAK_AVG_HI:`PEAK_AVG_LO];
        peak_scale_nxt    = beat_a_q[`PEAK_SCALE_HI:`PEAK_SCALE_LO];
        holdoff_nxt       = beat_b_q[`HOLDOFF_HI:`HOLDOFF_LO];
        interval_avg_nxt  = beat_b_q[`INTERVAL_AVG_HI:`INTERVAL_AVG_LO];
        holdoff_scale_nxt = beat_b_q[`HOLDOFF_SCALE_HI:`HOLDOFF_SCALE_LO];
        // Detector only runs with both enables set
        run_nxt           = beat_a_q[`BEAT_EN_BIT] & ecg_q[`ECG_EN_BIT];
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            polarity_r      <= PACE_RST[`POLARITY_BIT];
            bypass_r        <= PACE_RST[`DERIV_BYPASS_BIT];
            gain_r          <= PACE_RST[`PACE_GAIN_HI:`PACE_GAIN_LO];
            low_bw_r        <= PACE_RST[`MON_LBW_BIT];
            source_r        <= pace_beat_pkg::monitor_source_e'(PACE_RST[`MON_SRC_HI:`MON_SRC_LO]);
            pos_thr_r       <= PACE_RST[`POS_THR_HI:`POS_THR_LO];
            neg_thr_r       <= PACE_RST[`NEG_THR_HI:`NEG_THR_LO];
            window_r        <= BEAT_A_RST[`WINDOW_HI:`WINDOW_LO];
            beat_gain_r     <= BEAT_A_RST[`BGAIN_HI:`BGAIN_LO];
            peak_avg_r      <= BEAT_A_RST[`PEAK_AVG_HI:`PEAK_AVG_LO];
            peak_scale_r    <= BEAT_A_RST[`PEAK_SCALE_HI:`PEAK_SCALE_LO];
            holdoff_r       <= BEAT_B_RST[`HOLDOFF_HI:`HOLDOFF_LO];
            interval_avg_r  <= BEAT_B_RST[`INTERVAL_AVG_HI:`INTERVAL_AVG_LO];
            holdoff_scale_r <= BEAT_B_RST[`HOLDOFF_SCALE_HI:`HOLDOFF_SCALE_LO];
            run_r           <= 1'b0;
        end
        else
        begin
            polarity_r      <= polarity_nxt;
            bypass_r        <= bypass_nxt;
            gain_r          <= gain_nxt;
            low_bw_r        <= low_bw_nxt;
            source_r        <= source_nxt;
            pos_thr_r       <= pos_thr_nxt;
            neg_thr_r       <= neg_thr_nxt;
            window_r        <= window_nxt;
            beat_gain_r     <= beat_gain_nxt;
            peak_avg_r      <= peak_avg_nxt;
            peak_scale_r    <= peak_scale_nxt;
            holdoff_r       <= holdoff_nxt;
            interval_avg_r  <= interval_avg_nxt;
            holdoff_scale_r <= holdoff_scale_nxt;
            run_r           <= run_nxt;
        end
    end

    assign pacing_input_polarity        = polarity_r;
    assign derivative_stage_bypass      = bypass_r;
    assign pacing_gain_code             = gain_r;
    assign monitor_buffer_low_bandwidth = low_bw_r;
    assign monitor_output_source        = source_r;
    assign positive_threshold_code      = pos_thr_r;
    assign negative_threshold_code      = neg_thr_r;

    assign beat_window_width       = window_r;
    assign beat_detect_gain        = beat_gain_r;
    assign peak_average_weight     = peak_avg_r;
    assign peak_threshold_scale    = peak_scale_r;
    assign min_holdoff_count       = holdoff_r;
    assign interval_average_weight = interval_avg_r;
    assign holdoff_scale_factor    = holdoff_scale_r;
    assign beat_detector_run       = run_r;

endmodule

/* bench/pace_beat_config_monitor.sv */
// Concurrent checks on the pace and beat config bank ports
// Assumes bind into the design top, one clock domain on pclk
`timescale 1ns/1ps

module pace_beat_config_monitor #(
    parameter int ADDR_W = 12
) (
    // Clock and reset
    input wire logic                          pclk,
    input wire logic                          presetn,
    // APB
    input wire logic                          psel,
    input wire logic                          penable,
    input wire logic                          pwrite,
    input wire logic [ADDR_W-1:0]             paddr,
    input wire logic [31:0]                   pwdata,
    input wire logic [3:0]                    pstrb,
    input wire logic                          pready,
    input wire logic [31:0]                   prdata,
    input wire logic                          pslverr,
    // Fields
    input wire logic                          pacing_input_polarity,
    input wire pace_beat_pkg::monitor_source_e monitor_output_source,
    input wire logic [3:0]                    positive_threshold_code,
    input wire logic [3:0]                    negative_threshold_code,
    input wire logic [3:0]                    beat_window_width,
    input wire logic [5:0]                    min_holdoff_count,
    input wire logic                          beat_detector_run
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    // Full-word writes only; partial lanes would need per-byte expectations
    logic wr;
    assign wr = psel && penable && pready && pwrite && (pstrb == 4'hF);

    ////////////////////////////////////////////////////////////////////////////
    property p_ready_setup;
        psel && !penable |=> pready && penable;
    endproperty
    a_ready_setup: assert property (p_ready_setup) else $error("no pready after setup");
    property p_err_unmapped;
        pready && !(paddr inside {'h068, 'h074, 'h078, 'h080}) |-> pslverr && (prdata == 32'h0);
    endproperty
    a_err_unmapped: assert property (p_err_unmapped) else $error("unmapped access not refused");
    property p_rd_high;
        prdata[31:24] == 8'h00;
    endproperty
    a_rd_high: assert property (p_rd_high) else $error("read data upper byte set");
    property p_pol;
        wr && paddr == 'h068 |=> ##1 pacing_input_polarity == $past(pwdata[23], 2);
    endproperty
    a_pol: assert property (p_pol) else $error("polarity not updated");
    property p_src;
        wr && paddr == 'h068 |=> ##1 monitor_output_source == $past(pwdata[13:12], 2);
    endproperty
    a_src: assert property (p_src) else $error("monitor source not updated");
    property p_thr;
        wr && paddr == 'h068 |=> ##1 {positive_threshold_code, negative_threshold_code} == $past(pwdata[7:0], 2);
    endproperty
    a_thr: assert property (p_thr) else $error("thresholds not updated");
    property p_win;
        wr && paddr == 'h074 |=> ##1 beat_window_width == $past(pwdata[23:20], 2);
    endproperty
    a_win: assert property (p_win) else $error("window width not updated");
    property p_min_holdoff_count;
        wr && paddr == 'h078 |=> ##1 min_holdoff_count == $past(pwdata[21:16], 2);
    endproperty
    a_min_holdoff_count: assert property (p_min_holdoff_count) else $error("holdoff count not updated");
    property p_run_off;
        wr && paddr == 'h074 && !pwdata[15] |=> ##1 !beat_detector_run;
    endproperty
    a_run_off: assert property (p_run_off) else $error("detector runs while disabled");
endmodule

/* bench/pace_beat_config_regs_tb.sv */
// Self-checking bench for the pace and beat config bank
// Assumes the design answers APB in the access cycle after setup
`timescale 1ns/1ps

module pace_beat_config_regs_tb;
    logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
    logic [11:0] paddr = '0;
    logic [31:0] pwdata = '0, prdata, rd;
    logic [3:0]  pstrb = '0, pacing_gain_code, positive_threshold_code, negative_threshold_code;
    logic        pready, pslverr, er, pacing_input_polarity, derivative_stage_bypass;
    logic        monitor_buffer_low_bandwidth, beat_detector_run;
    logic [3:0]  beat_window_width, beat_detect_gain, peak_threshold_scale;
    logic [1:0]  peak_average_weight, interval_average_weight;
    logic [5:0]  min_holdoff_count;
    logic [2:0]  holdoff_scale_factor, gain3;
    pace_beat_pkg::monitor_source_e monitor_output_source;
    int          error_cnt = 0, checked = 0, cyc = 0;

    assign pacing_gain_code[3] = 1'b0;
    assign pacing_gain_code[2:0] = gain3;

    pace_beat_config_regs pace_beat_config_regs_inst (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
        .pwdata, .pstrb, .pready, .prdata, .pslverr, .pacing_input_polarity, .derivative_stage_bypass,
        .pacing_gain_code(gain3), .monitor_buffer_low_bandwidth, .monitor_output_source,
        .positive_threshold_code, .negative_threshold_code, .beat_window_width, .beat_detect_gain,
        .peak_average_weight, .peak_threshold_scale, .min_holdoff_count, .interval_average_weight,
        .holdoff_scale_factor, .beat_detector_run);

    initial
    begin
        forever #5 pclk = ~pclk;
    end

    ////////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("BAD %0t got %h exp %h", $time, got, exp);
        end
    endtask

    // Request held until pready is seen at a rising edge; only the bench timeout ends a hang
    task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
        @(posedge pclk);
        psel   <= 1'b1;
        pwrite <= w;
        paddr  <= a;
        pwdata <= d;
        pstrb  <= s;
        @(posedge pclk);
        penable <= 1'b1;
        do
        begin
            @(posedge pclk);
        end
        while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        xfer(1'b1, a, d, 4'hF);
    endtask

    task automatic rdc(input logic [11:0] a, input logic [31:0] exp, input logic experr);
        xfer(1'b0, a, 32'h0, 4'h0);
        chk(rd, exp);
        chk(er, experr);
    endtask

    // Fields follow the stored word one clock later
    task automatic settle();
        repeat (2) @(posedge pclk);
    endtask

    task automatic stop_test();
        $display("checks %0d errors %0d", checked, error_cnt);
        if (error_cnt == 0 && checked > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    always @(posedge pclk)
    begin
        cyc++;
        if (cyc == 3000)
        begin
            error_cnt++;
            stop_test();
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    initial
    begin
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        rdc(12'h068, 32'h000055, 1'b0);
        rdc(12'h074, 32'h3F2300, 1'b0);
        rdc(12'h078, 32'h202200, 1'b0);
        rdc(12'h080, 32'h000000, 1'b0);
        chk(positive_threshold_code, 5);
        chk(negative_threshold_code, 5);
        chk(beat_detector_run, 0);
        $display("test reset values done");
        // Resync after pacing writes is issued outside this bank, so none here
        wr(12'h068, 32'hFFFFFFFF);
        rdc(12'h068, 32'h8F70FF, 1'b0);
        settle();
        chk({pacing_input_polarity, derivative_stage_bypass, monitor_buffer_low_bandwidth}, 7);
        for (int i = 0; i < 8; i++)
        begin
            wr(12'h068, (i << 16) | ((i & 3) << 12) | ((15 - i) << 4) | (i + 8));
            settle();
            chk(pacing_gain_code, i);
            chk(monitor_output_source, i & 3);
            chk(positive_threshold_code, 15 - i);
            chk(negative_threshold_code, i + 8);
            chk({pacing_input_polarity, derivative_stage_bypass}, 0);
        end
        $display("test pacing fields done");
        wr(12'h074, 32'hFFFFFFFF);
        rdc(12'h074, 32'hFFBF00, 1'b0);
        wr(12'h078, 32'hFFFFFFFF);
        rdc(12'h078, 32'h3F3700, 1'b0);
        settle();
        chk({beat_window_width, beat_detect_gain, peak_average_weight, peak_threshold_scale}, 14'h3FFF);
        chk({min_holdoff_count, interval_average_weight, holdoff_scale_factor}, 11'h7FF);
        chk(beat_detector_run, 0);
        wr(12'h080, 32'h1);
        settle();
        chk(beat_detector_run, 1);
        wr(12'h074, 32'h0);
        settle();
        chk(beat_detector_run, 0);
        $display("test beat detector done");
        wr(12'h06C, 32'hFFFFFFFF);
        chk(er, 1);
        rdc(12'h06C, 32'h0, 1'b1);
        rdc(12'h068, 32'h07308F, 1'b0);
        xfer(1'b1, 12'h068, 32'h0, 4'b0001);
        rdc(12'h068, 32'h073000, 1'b0);
        $display("test refusals done");
        stop_test();
    end
endmodule

bind pace_beat_config_regs pace_beat_config_monitor #(.ADDR_W(ADDR_W)) pace_beat_config_monitor_inst (.pclk,
    .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .pready, .prdata, .pslverr,
    .pacing_input_polarity, .monitor_output_source, .positive_threshold_code, .negative_threshold_code,
    .beat_window_width, .min_holdoff_count, .beat_detector_run);
